/* core/iofam_pkg.sv */
// constants, register map and carrier types of the i/o function assignment mux
package iofam_pkg;

  localparam int DIN_N  = 5;
  localparam int DOUT_N = 2;
  localparam int RIN_N  = 16;
  localparam int ROUT_N = 16;
  localparam int PT_N   = DIN_N + RIN_N;
  localparam int FN_N   = 16;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_DIN_POL   = 12'h004;
  localparam logic [11:0] ADDR_DOUT_POL  = 12'h008;
  localparam logic [11:0] ADDR_RIN_IMG   = 12'h00c;
  localparam logic [11:0] ADDR_ROUT_IMG  = 12'h010;
  localparam logic [11:0] ADDR_FN_STAT   = 12'h014;
  localparam logic [11:0] ADDR_PIN_STAT  = 12'h018;
  localparam logic [11:0] ADDR_DIN_BASE  = 12'h040;
  localparam logic [11:0] ADDR_DOUT_BASE = 12'h060;
  localparam logic [11:0] ADDR_RIN_BASE  = 12'h080;
  localparam logic [11:0] ADDR_ROUT_BASE = 12'h0c0;

  // field positions
  localparam int CTRL_THREE_WIRE_BIT = 0;
  localparam int PIN_STAT_OUT_LSB    = 8;

  // reset values
  localparam logic        CTRL_RST      = 1'b0;
  localparam logic [4:0]  DIN_POL_RST   = 5'h00;
  localparam logic [1:0]  DOUT_POL_RST  = 2'h0;
  localparam logic [15:0] RIN_IMG_RST   = 16'h0000;

  // assignment codes, input functions
  localparam logic [7:0] IC_NONE       = 8'h00;
  localparam logic [7:0] IC_FAULT_CLR  = 8'h08;
  localparam logic [7:0] IC_INFO_CLR   = 8'h0e;
  localparam logic [7:0] IC_PANEL      = 8'h10;
  localparam logic [7:0] IC_TORQUE_CAP = 8'h16;
  localparam logic [7:0] IC_EXT_FAULT  = 8'h19;
  localparam logic [7:0] IC_RUN_FWD    = 8'h3a;
  localparam logic [7:0] IC_RUN_BWD    = 8'h3b;
  localparam logic [7:0] IC_SPD_SEL0   = 8'h40;
  localparam logic [7:0] IC_SPD_SEL1   = 8'h41;
  localparam logic [7:0] IC_SPD_SEL2   = 8'h42;
  localparam logic [7:0] IC_STOP_MODE  = 8'h48;
  localparam logic [7:0] IC_HOLD_FREE  = 8'h4a;
  localparam logic [7:0] IC_GP0        = 8'h50;
  localparam logic [7:0] IC_GP1        = 8'h51;
  localparam logic [7:0] IC_GP2        = 8'h52;
  localparam logic [7:0] IC_GP3        = 8'h53;

  // assignment codes, output functions
  localparam logic [7:0] OC_ALARM_A    = 8'h80;
  localparam logic [7:0] OC_FAULT_NC   = 8'h82;
  localparam logic [7:0] OC_SYS_BUSY   = 8'h85;
  localparam logic [7:0] OC_INFO       = 8'h88;
  localparam logic [7:0] OC_MOVE       = 8'h8c;
  localparam logic [7:0] OC_SPEED_PULS = 8'h93;
  localparam logic [7:0] OC_DIRECTION  = 8'h99;
  localparam logic [7:0] OC_TORQUE_LIM = 8'h9c;
  localparam logic [7:0] OC_SPEED_REAC = 8'h9d;
  localparam logic [7:0] OC_POWER_ON   = 8'h9e;

  // input function table, index k is bit k of the raw function vector
  localparam logic [FN_N-1:0][7:0] IN_CODES = {
    IC_GP3, IC_GP2, IC_GP1, IC_GP0, IC_HOLD_FREE, IC_STOP_MODE, IC_SPD_SEL2, IC_SPD_SEL1,
    IC_SPD_SEL0, IC_RUN_BWD, IC_RUN_FWD, IC_EXT_FAULT, IC_TORQUE_CAP, IC_PANEL,
    IC_INFO_CLR, IC_FAULT_CLR};
  localparam logic [FN_N-1:0] IN_ALL_MODE = 16'h001c;

  localparam logic [DIN_N-1:0][7:0]  DIN_CODE_RST  = {8'h08, 8'h40, 8'h48, 8'h3b, 8'h3a};
  localparam logic [DOUT_N-1:0][7:0] DOUT_CODE_RST = {8'h82, 8'h93};
  localparam logic [RIN_N-1:0][7:0]  RIN_CODE_RST  = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h08, 8'h00, 8'h48, 8'h3b, 8'h3a, 8'h42, 8'h41, 8'h40};
  localparam logic [ROUT_N-1:0][7:0] ROUT_CODE_RST = {
    8'h9c, 8'h9d, 8'h8c, 8'h00, 8'h00, 8'h9e, 8'h99, 8'h85,
    8'h80, 8'h88, 8'h48, 8'h3b, 8'h3a, 8'h42, 8'h41, 8'h40};

  // internal input functions delivered to the drive core
  typedef struct packed {
    logic gp3;
    logic gp2;
    logic gp1;
    logic gp0;
    logic hold_free;
    logic fwd_rev;
    logic run_brake;
    logic start_stop;
    logic stop_mode;
    logic speed_select_bit2;
    logic speed_select_bit1;
    logic speed_select_bit0;
    logic run_backward;
    logic run_forward;
    logic external_fault_input;
    logic torque_cap_enable;
    logic front_panel_permit;
    logic info_clear;
    logic fault_clear_request;
  } iofam_fn_t;

  // drive core status available to the outputs
  typedef struct packed {
    logic alarm_a;
    logic fault_output_nc;
    logic sys_busy;
    logic info;
    logic move;
    logic speed_pulse;
    logic direction;
    logic torque_limited;
    logic speed_reached;
    logic power_on;
  } iofam_st_t;

endpackage

/* core/iofam_sync.sv */
// two-stage synchroniser for the wired input terminals
`timescale 1ns/1ps
module iofam_sync
  import iofam_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire logic [DIN_N-1:0] async_in,
  output logic      [DIN_N-1:0] sync_out
);

  logic [DIN_N-1:0] meta_r;
  logic [DIN_N-1:0] sync_r;

  // reset to the idle-high level so no function pulses after reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

/* core/iofam_top.sv */
// i/o function assignment mux with apb register file
// Notes on behaviour
// - wired points on connector, network points via registers
// - external fault never taken from network inputs
// - speed pulse never placed on network outputs
// - speed pulse output ignores its polarity setting
// - three-wire mode renames codes 58, 59, 72
// - wired input codes reset to 58,59,72,64,8
// - ordinary functions OR all assigned points
// - permit, torque cap, fault default active unassigned
// - permit, torque cap, fault AND all points
// - polarity zero: low level means active
// - polarity one: high level means active
// - wired output codes reset to 147, 130
// - output polarity one energises on inactive function
// - sixteen network inputs share the input code space
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module iofam_top
  import iofam_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        wired_input_zero_in,
  input  wire logic        wired_input_one_in,
  input  wire logic        wired_input_two_in,
  input  wire logic        wired_input_three_in,
  input  wire logic        wired_input_four_in,
  output logic             wired_output_zero_out,
  output logic             wired_output_one_out,
  input  wire iofam_st_t   core_status_in,
  output iofam_fn_t        func_active_out,
  output logic      [15:0] network_out_image_out
);

  logic                      three_wire_r;
  logic [DIN_N-1:0]          din_pol_r;
  logic [DOUT_N-1:0]         dout_pol_r;
  logic [RIN_N-1:0]          rin_img_r;
  logic [DIN_N-1:0][7:0]     din_code_r;
  logic [DOUT_N-1:0][7:0]    dout_code_r;
  logic [RIN_N-1:0][7:0]     rin_code_r;
  logic [ROUT_N-1:0][7:0]    rout_code_r;
  logic [ROUT_N-1:0]         rout_img_r;
  logic [DOUT_N-1:0]         dout_r;
  iofam_fn_t                 fn_r;
  logic                      pready_r;
  logic                      pslverr_r;
  logic [31:0]               prdata_r;

  logic [DIN_N-1:0]          din_sync;
  logic [DIN_N-1:0]          din_act;
  logic [PT_N-1:0][7:0]      pt_code;
  logic [PT_N-1:0]           pt_act;
  logic [FN_N-1:0]           raw_fn;
  iofam_fn_t                 fn_nxt;
  logic [DOUT_N-1:0]         dout_nxt;
  logic [ROUT_N-1:0]         rout_nxt;

  logic                      setup_ph;
  logic                      wr_go;
  logic                      is_din;
  logic                      is_dout;
  logic                      is_rin;
  logic                      is_rout;
  logic [3:0]                idx;
  logic                      rd_hit;
  logic                      wr_refuse;
  logic [31:0]               rd_data;

  // combine every point carrying a code; all-mode functions default active
  function automatic logic gather(input logic [PT_N-1:0][7:0] codes,
                                  input logic [PT_N-1:0]      act,
                                  input logic [7:0]           code,
                                  input logic                 all_mode);
    logic hit;
    logic any_on;
    logic all_on;
    hit    = 1'b0;
    any_on = 1'b0;
    all_on = 1'b1;
    for (int i = 0; i < PT_N; i++) begin
      if (codes[i] == code) begin
        hit    = 1'b1;
        any_on = any_on | act[i];
        all_on = all_on & act[i];
      end
    end
    if (all_mode) begin
      gather = hit ? all_on : 1'b1;
    end else begin
      gather = any_on;
    end
  endfunction

  // level of an output function; input codes echo the combined input state
  function automatic logic out_level(input logic [7:0]      code,
                                     input logic [FN_N-1:0] raw,
                                     input iofam_st_t       st);
    logic v;
    v = 1'b0;
    case (code)
      OC_ALARM_A:    v = st.alarm_a;
      OC_FAULT_NC:   v = st.fault_output_nc;
      OC_SYS_BUSY:   v = st.sys_busy;
      OC_INFO:       v = st.info;
      OC_MOVE:       v = st.move;
      OC_SPEED_PULS: v = st.speed_pulse;
      OC_DIRECTION:  v = st.direction;
      OC_TORQUE_LIM: v = st.torque_limited;
      OC_SPEED_REAC: v = st.speed_reached;
      OC_POWER_ON:   v = st.power_on;
      default: begin
        for (int k = 0; k < FN_N; k++) begin
          if (code == IN_CODES[k]) begin
            v = raw[k];
          end
        end
      end
    endcase
    out_level = v;
  endfunction

  // wired terminals cross into the clock domain first
  iofam_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   ({wired_input_four_in, wired_input_three_in, wired_input_two_in,
                  wired_input_one_in, wired_input_zero_in}),
    .sync_out   (din_sync)
  );

  // no filter: the controller guarantees 2 ms levels, far above the sync delay
  always_comb begin
    for (int i = 0; i < DIN_N; i++) begin
      din_act[i] = din_pol_r[i] ? din_sync[i] : ~din_sync[i];
    end
    pt_code = {rin_code_r, din_code_r};
    pt_act  = {rin_img_r, din_act};
    for (int j = 0; j < RIN_N; j++) begin
      if (rin_code_r[j] == IC_EXT_FAULT) begin
        pt_code[DIN_N + j] = IC_NONE;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < FN_N; k++) begin
      raw_fn[k] = gather(pt_code, pt_act, IN_CODES[k], IN_ALL_MODE[k]);
    end
  end

  always_comb begin
    fn_nxt                      = '0;
    fn_nxt.fault_clear_request  = raw_fn[0];
    fn_nxt.info_clear           = raw_fn[1];
    fn_nxt.front_panel_permit   = raw_fn[2];
    fn_nxt.torque_cap_enable    = raw_fn[3];
    fn_nxt.external_fault_input = raw_fn[4];
    fn_nxt.run_forward          = ~three_wire_r & raw_fn[5];
    fn_nxt.run_backward         = ~three_wire_r & raw_fn[6];
    fn_nxt.stop_mode            = ~three_wire_r & raw_fn[10];
    fn_nxt.start_stop           = three_wire_r & raw_fn[5];
    fn_nxt.run_brake            = three_wire_r & raw_fn[6];
    fn_nxt.fwd_rev              = three_wire_r & raw_fn[10];
    fn_nxt.speed_select_bit0    = raw_fn[7];
    fn_nxt.speed_select_bit1    = raw_fn[8];
    fn_nxt.speed_select_bit2    = raw_fn[9];
    fn_nxt.hold_free            = raw_fn[11];
    fn_nxt.gp0                  = raw_fn[12];
    fn_nxt.gp1                  = raw_fn[13];
    fn_nxt.gp2                  = raw_fn[14];
    fn_nxt.gp3                  = raw_fn[15];
  end

  always_comb begin
    for (int i = 0; i < DOUT_N; i++) begin
      if (dout_code_r[i] == IC_NONE) begin
        dout_nxt[i] = 1'b0;
      end else if (dout_code_r[i] == OC_SPEED_PULS) begin
        dout_nxt[i] = out_level(dout_code_r[i], raw_fn, core_status_in);
      end else begin
        dout_nxt[i] = out_level(dout_code_r[i], raw_fn, core_status_in) ^ dout_pol_r[i];
      end
    end
    for (int j = 0; j < ROUT_N; j++) begin
      if (rout_code_r[j] == OC_SPEED_PULS) begin
        rout_nxt[j] = 1'b0;
      end else begin
        rout_nxt[j] = out_level(rout_code_r[j], raw_fn, core_status_in);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fn_r       <= '0;
      dout_r     <= '0;
      rout_img_r <= '0;
    end else begin
      fn_r       <= fn_nxt;
      dout_r     <= dout_nxt;
      rout_img_r <= rout_nxt;
    end
  end

  // apb decode; answer is prepared in the setup cycle so read data comes from flops
  assign setup_ph = psel_in & ~penable_in;
  assign wr_go    = psel_in & penable_in & pready_r & pwrite_in & ~pslverr_r;
  assign is_din   = (paddr_in[11:5] == ADDR_DIN_BASE[11:5]) && (paddr_in[4:2] < 3'h5);
  assign is_dout  = (paddr_in[11:3] == ADDR_DOUT_BASE[11:3]);
  assign is_rin   = (paddr_in[11:6] == ADDR_RIN_BASE[11:6]);
  assign is_rout  = (paddr_in[11:6] == ADDR_ROUT_BASE[11:6]);
  assign idx      = paddr_in[5:2];

  always_comb begin
    rd_hit    = 1'b1;
    wr_refuse = 1'b0;
    rd_data   = 32'h0000_0000;
    if (paddr_in[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (is_din) begin
      rd_data[7:0] = din_code_r[idx[2:0]];
    end else if (is_dout) begin
      rd_data[7:0] = dout_code_r[idx[0]];
    end else if (is_rin) begin
      rd_data[7:0] = rin_code_r[idx];
      wr_refuse    = pwrite_in && (pwdata_in[7:0] == IC_EXT_FAULT);
    end else if (is_rout) begin
      rd_data[7:0] = rout_code_r[idx];
      wr_refuse    = pwrite_in && (pwdata_in[7:0] == OC_SPEED_PULS);
    end else begin
      case (paddr_in)
        ADDR_CTRL:     rd_data[CTRL_THREE_WIRE_BIT] = three_wire_r;
        ADDR_DIN_POL:  rd_data[DIN_N-1:0] = din_pol_r;
        ADDR_DOUT_POL: rd_data[DOUT_N-1:0] = dout_pol_r;
        ADDR_RIN_IMG:  rd_data[RIN_N-1:0] = rin_img_r;
        ADDR_ROUT_IMG: rd_data[ROUT_N-1:0] = rout_img_r;
        ADDR_FN_STAT:  rd_data[$bits(iofam_fn_t)-1:0] = fn_r;
        ADDR_PIN_STAT: begin
          rd_data[DIN_N-1:0] = din_sync;
          rd_data[PIN_STAT_OUT_LSB +: DOUT_N] = dout_r;
        end
        default:       rd_hit = 1'b0;
      endcase
      wr_refuse = pwrite_in && ((paddr_in == ADDR_ROUT_IMG) || (paddr_in == ADDR_FN_STAT) ||
                                (paddr_in == ADDR_PIN_STAT));
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & (~rd_hit | wr_refuse);
      prdata_r  <= (setup_ph & ~pwrite_in & rd_hit) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      three_wire_r <= CTRL_RST;
      din_pol_r    <= DIN_POL_RST;
      dout_pol_r   <= DOUT_POL_RST;
    end else if (wr_go) begin
      if (paddr_in == ADDR_CTRL) begin
        three_wire_r <= pwdata_in[CTRL_THREE_WIRE_BIT];
      end
      if (paddr_in == ADDR_DIN_POL) begin
        din_pol_r <= pwdata_in[DIN_N-1:0];
      end
      if (paddr_in == ADDR_DOUT_POL) begin
        dout_pol_r <= pwdata_in[DOUT_N-1:0];
      end
    end
  end

  // network input image stands in for the serial engine's writes
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rin_img_r <= RIN_IMG_RST;
    end else if (wr_go && (paddr_in == ADDR_RIN_IMG)) begin
      rin_img_r <= pwdata_in[RIN_N-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      din_code_r  <= DIN_CODE_RST;
      dout_code_r <= DOUT_CODE_RST;
    end else if (wr_go && is_din) begin
      din_code_r[idx[2:0]] <= pwdata_in[7:0];
    end else if (wr_go && is_dout) begin
      dout_code_r[idx[0]] <= pwdata_in[7:0];
    end
  end

  // refused codes raise pslverr in setup, so wr_go never stores them
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rin_code_r  <= RIN_CODE_RST;
      rout_code_r <= ROUT_CODE_RST;
    end else if (wr_go && is_rin) begin
      rin_code_r[idx] <= pwdata_in[7:0];
    end else if (wr_go && is_rout) begin
      rout_code_r[idx] <= pwdata_in[7:0];
    end
  end

  assign prdata_out            = prdata_r;
  assign pready_out            = pready_r;
  assign pslverr_out           = pslverr_r;
  assign wired_output_zero_out = dout_r[0];
  assign wired_output_one_out  = dout_r[1];
  assign func_active_out       = fn_r;
  assign network_out_image_out = rout_img_r;

endmodule

/* testbench/iofam_ctl_model.sv */
// wired terminal driver standing in for the external controller
`timescale 1ns/1ps
module iofam_ctl_model #(
  parameter int HOLD_CYC = 20000
) (
  input  wire logic       sys_clk_in,
  input  wire logic [4:0] level_req_in,
  output logic      [4:0] pins_out
);
  int hold_r = 0;
  // pull-ups keep idle terminals high, the inactive level at polarity zero
  initial pins_out = 5'h1f;
  always @(posedge sys_clk_in) begin
    if (hold_r > 0) begin
      hold_r <= hold_r - 1;
    end else if (level_req_in !== pins_out) begin
      // no level is left before its minimum hold has run out
      pins_out <= level_req_in;
      hold_r   <= HOLD_CYC;
    end
  end
endmodule

/* testbench/iofam_asserts.sv */
// port assertions for the i/o function assignment mux
`timescale 1ns/1ps
module iofam_asserts
  import iofam_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        wired_output_zero_out,
  input wire logic        wired_output_one_out,
  input wire iofam_st_t   core_status_in
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [1:0] pol_r;
  logic       wr_ok;
  logic       setup_wr;
  assign wr_ok    = psel_in && penable_in && pwrite_in && pready_out && !pslverr_out;
  assign setup_wr = psel_in && !penable_in && pwrite_in && paddr_in[1:0] == 2'h0;
  // shadow of the wired output set-up, learnt from accepted writes only
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      c0_r  <= DOUT_CODE_RST[0];
      c1_r  <= DOUT_CODE_RST[1];
      pol_r <= DOUT_POL_RST;
    end else if (wr_ok) begin
      if (paddr_in == ADDR_DOUT_BASE) c0_r <= pwdata_in[7:0];
      if (paddr_in == ADDR_DOUT_BASE + 12'h004) c1_r <= pwdata_in[7:0];
      if (paddr_in == ADDR_DOUT_POL) pol_r <= pwdata_in[1:0];
    end
  end
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  AST_READY_AFTER_SETUP: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no answer in the cycle after setup");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside the access cycle");
  AST_NET_FAULT_REFUSED: assert property (setup_wr && paddr_in[11:6] == 6'h02
    && pwdata_in[7:0] == IC_EXT_FAULT |=> pslverr_out)
    else $error("external fault code taken by a network input");
  AST_NET_SPEED_REFUSED: assert property (setup_wr && paddr_in[11:6] == 6'h03
    && pwdata_in[7:0] == OC_SPEED_PULS |=> pslverr_out)
    else $error("speed pulse code taken by a network output");
  AST_SPEED_POL_IGNORED: assert property (c0_r == OC_SPEED_PULS
    |=> wired_output_zero_out == $past(core_status_in.speed_pulse))
    else $error("speed pulse output not in native sense");
  AST_OUT_POL: assert property (c1_r == OC_FAULT_NC && !wr_ok
    |=> wired_output_one_out == ($past(core_status_in.fault_output_nc) ^ pol_r[1]))
    else $error("wired output one polarity wrong");
  AST_CODE_ZERO_OFF: assert property (c1_r == IC_NONE |=> !wired_output_one_out)
    else $error("unassigned output energised");
endmodule

bind iofam_top iofam_asserts chk_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .wired_output_zero_out(wired_output_zero_out),
  .wired_output_one_out(wired_output_one_out), .core_status_in(core_status_in));

/* testbench/io_function_assignment_mux_tb.sv */
// self-checking bench for the i/o function assignment mux
`timescale 1ns/1ps
module io_function_assignment_mux_tb;
  import iofam_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic        psel       = 1'b0;
  logic        pen        = 1'b0;
  logic        pwr        = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  req        = 5'h1f;
  logic [4:0]  pins;
  logic        out0;
  logic        out1;
  iofam_st_t   st         = '0;
  iofam_fn_t   fn;
  logic [15:0] nimg;
  logic [15:0] v;
  logic [7:0]  din_rst [5] = '{8'h3a, 8'h3b, 8'h48, 8'h40, 8'h08};
  int          num_errors = 0;
  int          checks     = 0;
  int          j;

  always #50 sys_clk_in = ~sys_clk_in;

  iofam_top dut_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .wired_input_zero_in(pins[0]), .wired_input_one_in(pins[1]),
    .wired_input_two_in(pins[2]), .wired_input_three_in(pins[3]),
    .wired_input_four_in(pins[4]), .wired_output_zero_out(out0),
    .wired_output_one_out(out1), .core_status_in(st), .func_active_out(fn),
    .network_out_image_out(nimg));
  // short hold keeps the run brief; the design has no debounce to defeat
  iofam_ctl_model #(.HOLD_CYC(8)) ctl_u (.sys_clk_in(sys_clk_in), .level_req_in(req),
    .pins_out(pins));

  task automatic stop_test();
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sync(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // one apb transfer; request holds until ready is seen high at a rising edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    logic [31:0] rd;
    logic        er;
    int          n;
    n = 0;
    @(posedge sys_clk_in);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    pen <= 1'b1;
    // ends once ready is seen high; no cycle limit, so the watchdog guards it
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1);
    rd   = prdata;
    er   = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    chk(32'(n), 32'h1);
    chk(32'(er), 32'(ee));
    if (!w) chk(rd, ed);
  endtask

  task automatic pins_to(input logic [4:0] p);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    req <= p;
    while (pins !== p && n < 100) begin
      @(posedge sys_clk_in);
      n++;
    end
    sync(3);
  endtask

  task automatic fc6(input logic [5:0] e);
    chk(32'({fn.start_stop, fn.run_brake, fn.fwd_rev, fn.stop_mode, fn.run_backward,
             fn.run_forward}), 32'(e));
  endtask

  initial begin
    void'($urandom(32'ha336c058));
    repeat (20) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    sync(1);
    chk(32'(fn), 32'h00001c);
    acc(0, ADDR_FN_STAT, 0, 32'h1c, 0);
    acc(0, ADDR_PIN_STAT, 0, 32'h1f, 0);
    acc(1, ADDR_FN_STAT, 0, 0, 1);
    acc(0, ADDR_CTRL + 12'h001, 0, 0, 1);
    for (j = 0; j < 5; j++) acc(0, ADDR_DIN_BASE + 12'(4 * j), 0, 32'(din_rst[j]), 0);
    acc(0, ADDR_DOUT_BASE, 0, 32'h93, 0);
    acc(0, ADDR_DOUT_BASE + 12'h004, 0, 32'h82, 0);
    acc(0, ADDR_DIN_POL, 0, 32'h0, 0);
    acc(0, 12'h03c, 0, 32'h0, 1);
    pins_to(5'h18);
    fc6(6'b000111);
    acc(1, ADDR_CTRL, 32'h1, 0, 0);
    sync(1);
    fc6(6'b111000);
    acc(1, ADDR_CTRL, 32'h0, 0, 0);
    acc(1, ADDR_DIN_POL, 32'h7, 0, 0);
    sync(1);
    fc6(6'b000000);
    pins_to(5'h1f);
    fc6(6'b000111);
    acc(1, ADDR_DIN_POL, 32'h0, 0, 0);
    sync(1);
    fc6(6'b000000);
    repeat (8) begin
      v = 16'($urandom);
      acc(1, ADDR_RIN_IMG, 32'(v), 0, 0);
      sync(1);
      chk(32'({fn.fault_clear_request, fn.run_forward, fn.speed_select_bit0}),
          32'({v[7], v[3], v[0]}));
      chk(32'(nimg[5:0]), 32'(v[5:0]));
    end
    acc(1, ADDR_DIN_BASE + 12'h004, 32'(IC_PANEL), 0, 0);
    acc(1, ADDR_RIN_BASE + 12'h020, 32'(IC_PANEL), 0, 0);
    for (j = 0; j < 4; j++) begin
      pins_to(j[0] ? 5'h1d : 5'h1f);
      acc(1, ADDR_RIN_IMG, j[1] ? 32'h100 : 32'h0, 0, 0);
      sync(1);
      chk(32'({fn.front_panel_permit, fn.torque_cap_enable, fn.external_fault_input}),
          {29'h0, j == 3, 2'b11});
    end
    acc(1, ADDR_DIN_BASE + 12'h010, 32'(IC_EXT_FAULT), 0, 0);
    sync(1);
    chk(32'(fn.external_fault_input), 32'h0);
    acc(1, ADDR_RIN_IMG, 32'h0, 0, 0);
    j = $urandom_range(15, 0);
    acc(1, ADDR_RIN_BASE + 12'(4 * j), 32'h19, 0, 1);
    // network input eight was given the panel code above
    acc(0, ADDR_RIN_BASE + 12'(4 * j), 0, 32'(j == 8 ? IC_PANEL : RIN_CODE_RST[j]), 0);
    acc(1, ADDR_ROUT_BASE + 12'(4 * j), 32'h93, 0, 1);
    acc(0, ADDR_ROUT_BASE + 12'(4 * j), 0, 32'(ROUT_CODE_RST[j]), 0);
    acc(1, ADDR_DOUT_BASE, 32'h93, 0, 0);
    acc(1, ADDR_DOUT_POL, 32'h3, 0, 0);
    repeat (40) begin
      @(posedge sys_clk_in);
      st <= 10'($urandom);
      sync(1);
      chk(32'(out0), 32'(st.speed_pulse));
      chk(32'(out1), 32'(!st.fault_output_nc));
      chk(32'(nimg), 32'({st.torque_limited, st.speed_reached, st.move, 2'b00, st.power_on,
          st.direction, st.sys_busy, st.alarm_a, st.info, 6'h0}));
    end
    acc(1, ADDR_DOUT_BASE + 12'h004, 32'h0, 0, 0);
    @(posedge sys_clk_in);
    st <= '1;
    sync(1);
    chk(32'(out1), 32'h0);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    num_errors++;
    stop_test();
  end
endmodule
